// *** fca_filter_adc_ctrl.sv ***
// Filter clock generator, ready detection and converter sequencing with its register file.
//
// Contract
// - Read-only filter ready flag in bit six.
// - Ready rising edge sets filter interrupt flag.
// - Auto-convert bit five starts conversion on ready.
// - Prescale codes 0..6 divide by 8..512.
// - Prescale code seven divides by 1024.
// - Divide value N divides by N+1.
// - Unused bits read as zero, except source register bits four to one, which read back as written.
// - Current source enable powers amplifier and reference.
// - Four-bit current reference select, sixteen steps.
// - Battery sense enable drives bias strings.
// - Accumulate mode sums sixteen conversions.
// - After sixteenth, clear busy, raise interrupt.
// - Normal mode gives one 12-bit result.
// - Source chosen by source and channel fields.
// - Auto mode forces filter output as input.
// - Newest conversion request takes priority.
// - Source code 010 routes filter output.
`default_nettype none
module fca_filter_adc_ctrl #(
    parameter int CONV_LEN = fca_pkg::CONV_CYCLES
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire fca_pkg::fca_bus_req_t i_bus,
    output logic [7:0]                o_rdata,
    input  wire logic                 i_filter_ready,
    input  wire logic [11:0]          i_adc_sample,
    output logic                      o_filter_clk,
    output logic                      o_filter_irq,
    output logic                      o_adc_irq,
    output logic                      o_adc_sample_strobe,
    output logic [2:0]                o_adc_source_sel,
    output logic [3:0]                o_adc_channel_sel,
    output logic                      o_current_source_enable,
    output logic [3:0]                o_current_ref_voltage_sel,
    output logic                      o_battery_sense_enable
);
    // --------------------------------------------------------------
    // Registers written by software and state held by hardware
    // --------------------------------------------------------------
    logic [7:0]  filter_ctrl_reg;
    logic [7:0]  filter_div_reg;
    logic [7:0]  sensor_ctrl_reg;
    logic [7:0]  conv_ctrl_reg;
    logic [7:0]  conv_src_reg;
    logic        filter_flag_reg;
    logic        adc_flag_reg;
    logic        busy_reg;
    logic [15:0] result_reg;
    logic [15:0] acc_reg;
    logic [4:0]  sample_cnt_reg;
    logic [7:0]  conv_cnt_reg;
    logic [9:0]  pre_cnt_reg;
    logic [7:0]  div_cnt_reg;
    logic        fclk_reg;
    logic        rdy_meta_reg;
    logic        rdy_sync_reg;
    logic        rdy_prev_reg;
    logic        start_pend_reg;
    logic        start_dly_reg;
    fca_pkg::fca_state_t state_reg;

    logic        wr_ctrl;
    logic        ready_rise;
    logic        sw_start;
    logic        new_start;
    logic        conv_done;
    logic        acc_mode;
    logic [9:0]  pre_top;
    logic        pre_tick;
    logic [15:0] acc_next;

    assign wr_ctrl  = i_bus.wr && (i_bus.addr == fca_pkg::OFS_CONV_CTRL);
    assign acc_mode = sensor_ctrl_reg[fca_pkg::BIT_ACC_EN];

    // Control registers; reserved bits of filter and sensor control are masked so they read back zero.
    // filter and sensor reserved bits zero
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            filter_ctrl_reg <= fca_pkg::RST_BYTE;
            filter_div_reg  <= fca_pkg::RST_BYTE;
            sensor_ctrl_reg <= fca_pkg::RST_BYTE;
            conv_src_reg    <= fca_pkg::RST_BYTE;
        end
        else if (i_bus.wr)
        begin
            case (i_bus.addr)
                fca_pkg::OFS_FILTER_CTRL: filter_ctrl_reg <= i_bus.wdata & fca_pkg::CTRL_MASK;
                fca_pkg::OFS_FILTER_DIV:  filter_div_reg  <= i_bus.wdata;
                fca_pkg::OFS_SENSOR_CTRL: sensor_ctrl_reg <= i_bus.wdata & fca_pkg::SENSOR_MASK;
                fca_pkg::OFS_CONV_SRC:    conv_src_reg    <= i_bus.wdata;
                default:                  filter_ctrl_reg <= filter_ctrl_reg;
            endcase
        end
    end

    // Converter control; the start bit stays as written, busy is hardware-owned.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            conv_ctrl_reg <= fca_pkg::RST_BYTE;
        else if (wr_ctrl)
            conv_ctrl_reg <= i_bus.wdata;
    end

    // Start fires on the high-to-low edge of the start bit, so a write of one then zero starts.
    assign sw_start = wr_ctrl && conv_ctrl_reg[fca_pkg::BIT_START] && !i_bus.wdata[fca_pkg::BIT_START];

    // --------------------------------------------------------------
    // Filter clock: prescaler then N+1 divider
    // --------------------------------------------------------------
    // prescale by 4..512; the output toggle doubles it to 8..1024
    assign pre_top  = 10'((11'h1 << (filter_ctrl_reg[4:2] + fca_pkg::PRE_SHIFT_BASE - 4'h1)) - 11'h1);
    assign pre_tick = (pre_cnt_reg >= pre_top);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pre_cnt_reg <= 10'h000;
        else if (pre_tick)
            pre_cnt_reg <= 10'h000;
        else
            pre_cnt_reg <= pre_cnt_reg + 10'h001;
    end

    // The output toggles on each divided tick, so the prescaler ticks at twice the base rate.
    // divide by N plus one
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            div_cnt_reg <= 8'h00;
            fclk_reg    <= 1'b0;
        end
        else if (pre_tick)
        begin
            if (div_cnt_reg >= filter_div_reg)
            begin
                div_cnt_reg <= 8'h00;
                fclk_reg    <= !fclk_reg;
            end
            else
                div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // --------------------------------------------------------------
    // Ready detection and filter interrupt flag
    // --------------------------------------------------------------
    // Ready comes from the analog side, so it is synchronised before any edge logic sees it.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rdy_meta_reg <= 1'b0;
            rdy_sync_reg <= 1'b0;
            rdy_prev_reg <= 1'b0;
        end
        else
        begin
            rdy_meta_reg <= i_filter_ready;
            rdy_sync_reg <= rdy_meta_reg;
            rdy_prev_reg <= rdy_sync_reg;
        end
    end

    assign ready_rise = rdy_sync_reg && !rdy_prev_reg;

    // Flag clears by writing one to it; a simultaneous edge wins over the clear.
    // set interrupt flag
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            filter_flag_reg <= 1'b0;
        else if (ready_rise)
            filter_flag_reg <= 1'b1;
        else if (i_bus.wr && i_bus.addr == fca_pkg::OFS_CONV_SRC && i_bus.wdata[fca_pkg::BIT_FILT_FLAG])
            filter_flag_reg <= 1'b0;
    end

    // --------------------------------------------------------------
    // Conversion sequencer
    // --------------------------------------------------------------
    // auto trigger on ready
    assign new_start = conv_ctrl_reg[fca_pkg::BIT_CONV_EN]
                       && (sw_start || (ready_rise && filter_ctrl_reg[fca_pkg::BIT_AUTO]));
    assign conv_done = (state_reg == fca_pkg::FCA_CONV) && (conv_cnt_reg == 8'(CONV_LEN - 1));
    assign acc_next  = acc_reg + {4'h0, i_adc_sample};

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            start_pend_reg <= 1'b0;
            start_dly_reg  <= 1'b0;
        end
        else
        begin
            start_pend_reg <= new_start;
            start_dly_reg  <= start_pend_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg      <= fca_pkg::FCA_IDLE;
            busy_reg       <= 1'b0;
            conv_cnt_reg   <= 8'h00;
            sample_cnt_reg <= 5'h00;
            acc_reg        <= 16'h0000;
            result_reg     <= 16'h0000;
            adc_flag_reg   <= 1'b0;
        end
        else
        begin
            adc_flag_reg <= 1'b0;
            if (new_start)
            begin
                state_reg      <= fca_pkg::FCA_CONV;
                busy_reg       <= 1'b1;
                conv_cnt_reg   <= 8'h00;
                sample_cnt_reg <= 5'h00;
                acc_reg        <= 16'h0000;
            end
            else if (!conv_ctrl_reg[fca_pkg::BIT_CONV_EN])
            begin
                state_reg <= fca_pkg::FCA_IDLE;
                busy_reg  <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    fca_pkg::FCA_IDLE:
                        conv_cnt_reg <= 8'h00;
                    fca_pkg::FCA_CONV:
                    begin
                        // The sample stands only in the strobe cycle, so it is summed there.
                        if (conv_done)
                        begin
                            state_reg <= fca_pkg::FCA_NEXT;
                            acc_reg   <= acc_next;
                        end
                        else
                            conv_cnt_reg <= conv_cnt_reg + 8'h01;
                    end
                    fca_pkg::FCA_NEXT:
                    begin
                        conv_cnt_reg <= 8'h00;
                        if (acc_mode && (sample_cnt_reg != fca_pkg::ACC_SAMPLES - 5'h01))
                        begin
                            sample_cnt_reg <= sample_cnt_reg + 5'h01;
                            state_reg      <= fca_pkg::FCA_CONV;
                        end
                        else
                        begin
                            result_reg   <= acc_mode ? acc_reg : {4'h0, acc_reg[11:0]};
                            busy_reg     <= 1'b0;
                            adc_flag_reg <= 1'b1;
                            state_reg    <= fca_pkg::FCA_IDLE;
                        end
                    end
                    default:
                        state_reg <= fca_pkg::FCA_IDLE;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // Outputs and read port
    // --------------------------------------------------------------
    // auto mode forces filter
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_adc_source_sel  <= 3'h0;
            o_adc_channel_sel <= 4'h0;
        end
        else
        begin
            o_adc_source_sel  <= filter_ctrl_reg[fca_pkg::BIT_AUTO] ? fca_pkg::SRC_FILTER : conv_src_reg[7:5];
            o_adc_channel_sel <= conv_ctrl_reg[3:0];
        end
    end

    assign o_current_source_enable   = sensor_ctrl_reg[fca_pkg::BIT_CUR_EN];
    assign o_current_ref_voltage_sel = sensor_ctrl_reg[3:0];
    assign o_battery_sense_enable    = sensor_ctrl_reg[fca_pkg::BIT_BAT_EN];
    assign o_filter_clk              = fclk_reg;
    assign o_filter_irq              = filter_flag_reg;
    assign o_adc_irq                 = adc_flag_reg;
    assign o_adc_sample_strobe       = conv_done;

    // Result format follows accumulate mode and the format bit; unused bits read zero except source register bits 4:1.
    // ready flag in bit six
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rdata <= 8'h00;
        else if (i_bus.rd)
        begin
            case (i_bus.addr)
                fca_pkg::OFS_FILTER_CTRL: o_rdata <= {1'b0, rdy_sync_reg, filter_ctrl_reg[5:0]};
                fca_pkg::OFS_FILTER_DIV:  o_rdata <= filter_div_reg;
                fca_pkg::OFS_SENSOR_CTRL: o_rdata <= sensor_ctrl_reg;
                fca_pkg::OFS_CONV_CTRL:   o_rdata <= {conv_ctrl_reg[7], busy_reg, conv_ctrl_reg[5:0]};
                fca_pkg::OFS_CONV_SRC:    o_rdata <= {conv_src_reg[7:1], filter_flag_reg};
                fca_pkg::OFS_RESULT_LOW:
                    o_rdata <= (acc_mode || conv_ctrl_reg[fca_pkg::BIT_FORMAT]) ? result_reg[7:0]
                                                                              : {result_reg[3:0], 4'h0};
                fca_pkg::OFS_RESULT_HIGH:
                    o_rdata <= (acc_mode || conv_ctrl_reg[fca_pkg::BIT_FORMAT]) ? result_reg[15:8]
                                                                              : result_reg[11:4];
                default:                  o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence s_ready_edge;
        $rose(rdy_sync_reg);
    endsequence

    ready_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_ready_edge |=> filter_flag_reg)
        else $error("Filter flag not set after ready edge.");

    pulse_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ready_rise |=> !ready_rise)
        else $error("Ready pulse longer than one cycle.");

    auto_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (ready_rise && filter_ctrl_reg[fca_pkg::BIT_AUTO] && conv_ctrl_reg[fca_pkg::BIT_CONV_EN]) |=> busy_reg)
        else $error("Auto conversion did not start.");

    no_auto_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!busy_reg && ready_rise && !filter_ctrl_reg[fca_pkg::BIT_AUTO] && !sw_start) |=> !busy_reg)
        else $error("Conversion started without auto enable.");

    auto_src_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        filter_ctrl_reg[fca_pkg::BIT_AUTO] |=> (o_adc_source_sel == fca_pkg::SRC_FILTER))
        else $error("Auto mode did not force filter source.");

    rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !filter_ctrl_reg[7] && !sensor_ctrl_reg[4])
        else $error("Reserved bit set.");

    acc_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        new_start |=> (acc_reg == 16'h0000 && sample_cnt_reg == 5'h00))
        else $error("Accumulator not cleared at start.");

    done_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(busy_reg) && conv_ctrl_reg[fca_pkg::BIT_CONV_EN] |-> adc_flag_reg)
        else $error("Busy cleared without converter interrupt.");

    div_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (pre_tick && div_cnt_reg >= filter_div_reg) |=> $changed(fclk_reg))
        else $error("Filter clock did not toggle at divider wrap.");
endmodule
`default_nettype wire

// *** fca_pkg.sv ***
// Package of register map, field layout and encodings for the filter clock and converter trigger block.
`default_nettype none
package fca_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [3:0] OFS_FILTER_CTRL  = 4'h0;
    localparam logic [3:0] OFS_FILTER_DIV   = 4'h1;
    localparam logic [3:0] OFS_SENSOR_CTRL  = 4'h2;
    localparam logic [3:0] OFS_CONV_CTRL    = 4'h3;
    localparam logic [3:0] OFS_CONV_SRC     = 4'h4;
    localparam logic [3:0] OFS_RESULT_LOW   = 4'h5;
    localparam logic [3:0] OFS_RESULT_HIGH  = 4'h6;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int BIT_READY      = 6;
    localparam int BIT_AUTO       = 5;
    localparam int BIT_PRE_LO     = 2;
    localparam int BIT_CUR_EN     = 7;
    localparam int BIT_BAT_EN     = 6;
    localparam int BIT_ACC_EN     = 5;
    localparam int BIT_START      = 7;
    localparam int BIT_BUSY       = 6;
    localparam int BIT_CONV_EN    = 5;
    localparam int BIT_FORMAT     = 4;
    localparam int BIT_FILT_FLAG  = 0;
    // --------------------------------------------------------------
    // Reset values, codes and counts
    // --------------------------------------------------------------
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [2:0] SRC_FILTER     = 3'h2;
    localparam logic [4:0] ACC_SAMPLES    = 5'h10;
    localparam logic [3:0] PRE_SHIFT_BASE = 4'h3;
    localparam logic [7:0] CTRL_MASK      = 8'h3c;
    localparam logic [7:0] SENSOR_MASK    = 8'hef;
    localparam int         CONV_CYCLES    = 16;

    // Register bus request carried as one bundle.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } fca_bus_req_t;

    // Converter conversion state.
    typedef enum logic [2:0] {
        FCA_IDLE = 3'b001,
        FCA_CONV = 3'b010,
        FCA_NEXT = 3'b100
    } fca_state_t;
endpackage
`default_nettype wire

// *** fca_analog_model.sv ***
// Behavioural model of the analog filter and converter front end facing the control block.
`default_nettype none
module fca_analog_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ready_cmd,
    input  wire logic [11:0] i_value,
    input  wire logic        i_sample_strobe,
    output logic             o_filter_ready,
    output logic [11:0]      o_sample,
    output logic [15:0]      o_strobe_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // The ready level settles a few nanoseconds off the clock, as an unrelated analog source would.
    assign #3 o_filter_ready = i_ready_cmd;

    // twelve-bit sample
    // The sample is valid only in the strobe cycle; otherwise the inverse shows, so a late capture is caught.
    assign o_sample = i_sample_strobe ? i_value : ~i_value;

    // Counts captured samples so the bench can tell how many conversions really ran.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_strobe_count <= 16'h0000;
        else if (i_sample_strobe)
            o_strobe_count <= o_strobe_count + 16'h0001;
    end
endmodule
`default_nettype wire

// *** fca_filter_adc_ctrl_tb.sv ***
// Self-checking testbench for the filter clock and converter trigger block.
`default_nettype none
module fca_filter_adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV_LEN = 8;
    logic                  i_clk;
    logic                  i_rst_b;
    fca_pkg::fca_bus_req_t i_bus;
    logic [7:0]            o_rdata;
    logic                  ready_cmd;
    logic                  filter_ready;
    logic [11:0]           value;
    logic [11:0]           sample;
    logic                  o_filter_clk;
    logic                  o_filter_irq;
    logic                  o_adc_irq;
    logic                  strobe;
    logic [2:0]            src_sel;
    logic [3:0]            chan_sel;
    logic                  cur_en;
    logic [3:0]            ref_sel;
    logic                  bat_en;
    logic [15:0]           strobes;
    int                    irq_count = 0;
    int                    num_errors = 0;
    int                    num_checks = 0;
    int                    conv_lat;

    fca_filter_adc_ctrl #(.CONV_LEN(CONV_LEN)) fca_filter_adc_ctrl_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata), .i_filter_ready(filter_ready),
        .i_adc_sample(sample), .o_filter_clk(o_filter_clk), .o_filter_irq(o_filter_irq), .o_adc_irq(o_adc_irq),
        .o_adc_sample_strobe(strobe), .o_adc_source_sel(src_sel), .o_adc_channel_sel(chan_sel),
        .o_current_source_enable(cur_en), .o_current_ref_voltage_sel(ref_sel), .o_battery_sense_enable(bat_en));

    fca_analog_model fca_analog_model_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ready_cmd(ready_cmd), .i_value(value),
        .i_sample_strobe(strobe), .o_filter_ready(filter_ready), .o_sample(sample), .o_strobe_count(strobes));

    // Free-running 125 MHz system clock.
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // Counts interrupt pulses; a pulse is one cycle, so each edge seeing it high is one event.
    always @(posedge i_clk)
    begin
        if (o_adc_irq === 1'b1)
            irq_count++;
    end

    // ----------------------------------------------------------------
    // Reporting and bus helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One settled cycle; a wait that runs too long ends the run as a failure.
    task automatic step(inout int cnt);
        @(posedge i_clk);
        #1;
        cnt++;
        if (cnt > 5000)
        begin
            num_errors++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        chk({8'h00, o_rdata}, {8'h00, e});
    endtask

    // A start is the start bit written high and then low again.
    task automatic start(input logic [7:0] ctl);
        wr(fca_pkg::OFS_CONV_CTRL, 8'h80 | ctl);
        wr(fca_pkg::OFS_CONV_CTRL, ctl);
    endtask

    task automatic wait_irq(output int n);
        int c0;
        c0 = irq_count;
        n = 0;
        while (irq_count == c0)
            step(n);
    endtask

    task automatic drive(input logic r, input logic [11:0] v);
        @(posedge i_clk);
        ready_cmd <= r;
        value     <= v;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        int r;
        rd_chk(fca_pkg::OFS_FILTER_CTRL, 8'h00);
        rd_chk(fca_pkg::OFS_FILTER_DIV, 8'h00);
        rd_chk(fca_pkg::OFS_SENSOR_CTRL, 8'h00);
        wr(fca_pkg::OFS_FILTER_CTRL, 8'hff);
        rd_chk(fca_pkg::OFS_FILTER_CTRL, 8'h3c);
        wr(fca_pkg::OFS_FILTER_DIV, 8'ha5);
        rd_chk(fca_pkg::OFS_FILTER_DIV, 8'ha5);
        wr(fca_pkg::OFS_SENSOR_CTRL, 8'hff);
        rd_chk(fca_pkg::OFS_SENSOR_CTRL, 8'hef);
        chk({15'h0, cur_en}, 16'h0001);
        chk({15'h0, bat_en}, 16'h0001);
        for (r = 0; r < 16; r++)
        begin
            wr(fca_pkg::OFS_SENSOR_CTRL, {4'h4, r[3:0]});
            chk({12'h0, ref_sel}, r[15:0]);
            chk({15'h0, cur_en}, 16'h0000);
        end
        wr(fca_pkg::OFS_SENSOR_CTRL, 8'h00);
        chk({15'h0, bat_en}, 16'h0000);
        wr(4'hf, 8'h55);
        rd_chk(4'hf, 8'h00);
        wr(fca_pkg::OFS_FILTER_CTRL, 8'h00);
    endtask

    // Measures one full filter clock period, from the first toggle to the third.
    task automatic t_clk(input int p, input int n);
        int cnt;
        int k;
        logic last;
        wr(fca_pkg::OFS_FILTER_DIV, n[7:0]);
        wr(fca_pkg::OFS_FILTER_CTRL, {3'b000, p[2:0], 2'b00});
        last = o_filter_clk;
        cnt = 0;
        k = 0;
        while (k < 3)
        begin
            step(cnt);
            if (o_filter_clk !== last)
            begin
                last = o_filter_clk;
                k++;
                if (k == 3)
                    chk(cnt[15:0], 16'((1 << (p + 3)) * (n + 1)));
                if (k == 1)
                    cnt = 0;
            end
        end
    endtask

    task automatic t_ready();
        drive(1'b1, 12'h000);
        repeat (8) @(posedge i_clk);
        rd_chk(fca_pkg::OFS_FILTER_CTRL, 8'h40);
        chk({15'h0, o_filter_irq}, 16'h0001);
        rd_chk(fca_pkg::OFS_CONV_SRC, 8'h01);
        wr(fca_pkg::OFS_CONV_SRC, 8'h01);
        repeat (8) @(posedge i_clk);
        chk({15'h0, o_filter_irq}, 16'h0000);
        drive(1'b0, 12'h000);
        repeat (8) @(posedge i_clk);
        rd_chk(fca_pkg::OFS_FILTER_CTRL, 8'h00);
    endtask

    task automatic t_auto();
        int n;
        int c0;
        drive(1'b0, 12'h5a3);
        wr(fca_pkg::OFS_CONV_CTRL, 8'h23);
        wr(fca_pkg::OFS_FILTER_CTRL, 8'h20);
        drive(1'b1, 12'h5a3);
        wait_irq(n);
        chk({13'h0, src_sel}, 16'h0002);
        rd_chk(fca_pkg::OFS_RESULT_HIGH, 8'h5a);
        rd_chk(fca_pkg::OFS_RESULT_LOW, 8'h30);
        drive(1'b0, 12'h5a3);
        wr(fca_pkg::OFS_FILTER_CTRL, 8'h00);
        c0 = irq_count;
        drive(1'b1, 12'h5a3);
        repeat (40) @(posedge i_clk);
        chk(16'(irq_count - c0), 16'h0000);
        drive(1'b0, 12'h000);
        wr(fca_pkg::OFS_CONV_SRC, 8'h01);
    endtask

    task automatic t_src();
        int s;
        int n;
        for (s = 0; s < 8; s++)
        begin
            wr(fca_pkg::OFS_CONV_SRC, {s[2:0], 5'h00});
            start({4'h2, s[3:0]});
            wait_irq(n);
            chk({13'h0, src_sel}, s[15:0]);
            chk({12'h0, chan_sel}, s[15:0]);
        end
        wr(fca_pkg::OFS_CONV_SRC, 8'h00);
    endtask

    task automatic t_normal();
        logic [15:0] s0;
        drive(1'b0, 12'habc);
        s0 = strobes;
        start(8'h20);
        wait_irq(conv_lat);
        chk(conv_lat[15:0], 16'(CONV_LEN + 2));
        chk(strobes - s0, 16'h0001);
        rd_chk(fca_pkg::OFS_RESULT_HIGH, 8'hab);
        rd_chk(fca_pkg::OFS_RESULT_LOW, 8'hc0);
        start(8'h30);
        wait_irq(conv_lat);
        rd_chk(fca_pkg::OFS_RESULT_HIGH, 8'h0a);
        rd_chk(fca_pkg::OFS_RESULT_LOW, 8'hbc);
    endtask

    // Two sequences in a row: the second sum must not carry the first.
    task automatic t_accum();
        int k;
        int n;
        int c0;
        logic [15:0] s0;
        drive(1'b0, 12'hfff);
        wr(fca_pkg::OFS_SENSOR_CTRL, 8'h20);
        for (k = 0; k < 2; k++)
        begin
            s0 = strobes;
            c0 = irq_count;
            start(8'h20);
            wait_irq(n);
            chk(strobes - s0, 16'h0010);
            chk(16'(irq_count - c0), 16'h0001);
            rd_chk(fca_pkg::OFS_CONV_CTRL, 8'h20);
            rd_chk(fca_pkg::OFS_RESULT_HIGH, 8'hff);
            rd_chk(fca_pkg::OFS_RESULT_LOW, 8'hf0);
        end
        wr(fca_pkg::OFS_SENSOR_CTRL, 8'h00);
    endtask

    // A second start before the first sample is taken restarts the conversion.
    task automatic t_restart();
        int n;
        logic [15:0] s0;
        drive(1'b0, 12'h123);
        s0 = strobes;
        start(8'h20);
        start(8'h20);
        wait_irq(n);
        chk(n[15:0], conv_lat[15:0]);
        chk(strobes - s0, 16'h0001);
        rd_chk(fca_pkg::OFS_RESULT_LOW, 8'h30);
    endtask

    // Main sequence: reset, then every scenario in turn.
    initial
    begin
        int p;
        i_rst_b   = 1'b0;
        i_bus     = '0;
        ready_cmd = 1'b0;
        value     = 12'h000;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_regs();
        // the 488 Hz setting (code 7, divide 249) spans 256000 cycles, so shorter ratios prove the divider.
        for (p = 0; p < 7; p++)
            t_clk(p, 0);
        t_clk(7, 0);
        t_clk(0, 255);
        t_clk(2, 5);
        wr(fca_pkg::OFS_FILTER_CTRL, 8'h00);
        t_ready();
        t_auto();
        t_src();
        t_normal();
        t_accum();
        t_restart();
        end_of_test();
    end
endmodule
`default_nettype wire
